// ===== verilog/tco_pkg.sv
// constants, types and register map for the 16-bit timer compare-output block
// assumes one synchronous clock domain and an apb slave with 32-bit data
package tco_pkg;

	// --------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_COUNT  = 8'h08;
	localparam logic [7:0] OFS_CMP_A  = 8'h0C;
	localparam logic [7:0] OFS_CMP_B  = 8'h10;
	localparam logic [7:0] OFS_CMP_C  = 8'h14;
	localparam logic [7:0] OFS_CAP    = 8'h18;
	localparam logic [7:0] OFS_FLAGS  = 8'h1C;
	localparam logic [7:0] OFS_PINS   = 8'h20;

	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int CTRL_A_CHA_LSB = 6;
	localparam int CTRL_A_CHB_LSB = 4;
	localparam int CTRL_A_CHC_LSB = 2;
	localparam int CTRL_A_WGM_LSB = 0;
	localparam int CTRL_B_WGM_LSB = 3;
	localparam int CTRL_B_CS_LSB  = 0;
	localparam int FLAG_OVF       = 0;
	localparam int FLAG_CAP       = 1;
	localparam int FLAG_MATCH_LSB = 2;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  CTRL_B_MSK = 8'h1F;
	localparam logic [15:0] CNT_RST    = 16'h0000;
	localparam logic [4:0]  FLAGS_RST  = 5'h00;

	// --------------------------------------------------------------
	// counter limits and prescaler counts
	// --------------------------------------------------------------
	localparam logic [15:0] VAL_BOTTOM = 16'h0000;
	localparam logic [15:0] VAL_MAX    = 16'hFFFF;
	localparam logic [15:0] VAL_TOP8   = 16'h00FF;
	localparam logic [15:0] VAL_TOP9   = 16'h01FF;
	localparam logic [15:0] VAL_TOP10  = 16'h03FF;
	localparam logic [9:0]  PSC_M8     = 10'h007;
	localparam logic [9:0]  PSC_M64    = 10'h03F;
	localparam logic [9:0]  PSC_M256   = 10'h0FF;
	localparam logic [9:0]  PSC_M1024  = 10'h3FF;

	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		WC_NORMAL = 3'b000,
		WC_PHASE  = 3'b001,
		WC_CTC    = 3'b010,
		WC_FAST   = 3'b011,
		WC_BOTUPD = 3'b100,
		WC_RSVD   = 3'b101
	} tco_wclass_t;

	typedef enum logic [2:0] {
		TS_MAX  = 3'b000,
		TS_8    = 3'b001,
		TS_9    = 3'b010,
		TS_10   = 3'b011,
		TS_CMPA = 3'b100,
		TS_CAP  = 3'b101
	} tco_topsel_t;

	typedef enum logic {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} tco_dir_t;

	typedef struct packed {
		logic [1:0] mode;
		logic       match;
		logic       eq_top;
		logic       eq_bottom;
	} tco_chan_t;

endpackage

// ===== verilog/tco_tick_gen.sv
// prescaler producing the single-cycle timer tick enable
// assumes the external count pin is asynchronous to clk_sys
`timescale 1ns/100ps
module tco_tick_gen (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic [2:0] clk_sel,
	input  wire logic       ext_count_pin,
	output logic            timer_tick_enable
);
	import tco_pkg::*;

	logic [9:0] psc_r;
	logic [9:0] psc_nxt;
	logic [2:0] ext_r;
	logic [2:0] ext_nxt;
	logic [9:0] msk;

	// --------------------------------------------------------------
	// prescaler and pin synchroniser
	// --------------------------------------------------------------
	always_comb begin
		psc_nxt = (clk_sel == 3'h0) ? 10'h000 : psc_r + 10'h001;
		ext_nxt = {ext_r[1:0], ext_count_pin};
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			psc_r <= 10'h000;
			ext_r <= 3'h0;
		end else begin
			psc_r <= psc_nxt;
			ext_r <= ext_nxt;
		end
	end

	// tick is an enable only, never a clock (RQ1)
	always_comb begin
		msk = PSC_M8;
		case (clk_sel)
			3'h2:    msk = PSC_M8;
			3'h3:    msk = PSC_M64;
			3'h4:    msk = PSC_M256;
			3'h5:    msk = PSC_M1024;
			default: msk = PSC_M8;
		endcase
		case (clk_sel)
			3'h0:    timer_tick_enable = 1'b0;
			3'h1:    timer_tick_enable = 1'b1;
			// edge taken from stages 1 and 2 only, stage 0 is metastable
			3'h6:    timer_tick_enable = ext_r[2] & ~ext_r[1];
			3'h7:    timer_tick_enable = ~ext_r[2] & ext_r[1];
			default: timer_tick_enable = ((psc_r & msk) == msk);
		endcase
	end
endmodule

// ===== verilog/tco_chan_out.sv
// one compare-output channel: waveform flop and pin override
// assumes match flags are qualified by the timer tick upstream; top flags are not
`timescale 1ns/100ps
module tco_chan_out #(
	parameter bit IS_A = 1'b0
) (
	input  wire logic                 clk_sys,
	input  wire logic                 arst_n,
	input  wire logic                 tick,
	input  wire tco_pkg::tco_wclass_t wclass,
	input  wire logic [3:0]           wgm,
	input  wire logic                 at_top,
	input  wire tco_pkg::tco_dir_t    dir,
	input  wire tco_pkg::tco_chan_t   ch,
	output logic                      wave_out,
	output logic                      pin_override
);
	import tco_pkg::*;

	logic wave_r;
	logic wave_nxt;
	logic ovr_r;
	logic ovr_nxt;
	logic tog_ok;

	// --------------------------------------------------------------
	// mode decode and output actions
	// --------------------------------------------------------------
	always_comb begin
		case (wclass)
			WC_NORMAL, WC_CTC: tog_ok = 1'b1; // RQ11
			WC_FAST:           tog_ok = IS_A & (wgm[3:1] == 3'b111); // RQ12
			WC_PHASE,
			WC_BOTUPD:         tog_ok = IS_A & (wgm[3:2] == 2'b10); // RQ16
			default:           tog_ok = 1'b0;
		endcase
		// either mode bit set takes the pin, except a toggle barred in this mode or channel and the reserved mode (RQ9)
		ovr_nxt = (ch.mode != 2'b00) && (ch.mode != 2'b01 || tog_ok) && (wclass != WC_RSVD);
		wave_nxt = wave_r;
		if (tick && ovr_nxt) begin // RQ21
			if (ch.mode == 2'b01) begin
				if (ch.match) begin
					wave_nxt = ~wave_r;
				end
			end else begin
				case (wclass)
					WC_NORMAL, WC_CTC: begin
						if (ch.match) begin
							wave_nxt = ch.mode[0]; // RQ11
						end
					end
					WC_FAST: begin
						// top action wins, a match at top is dropped (RQ15)
						if (at_top) begin
							wave_nxt = ~ch.mode[0]; // RQ13 RQ14
						end else if (ch.match) begin
							wave_nxt = ch.mode[0]; // RQ13 RQ14
						end
					end
					WC_PHASE, WC_BOTUPD: begin
						if (ch.eq_bottom) begin
							wave_nxt = ch.mode[0]; // RQ20
						end else if (ch.eq_top) begin
							wave_nxt = ~ch.mode[0]; // RQ20
						end else if (ch.match) begin
							wave_nxt = (dir == DIR_UP) ? ch.mode[0] : ~ch.mode[0]; // RQ17 RQ18
						end
					end
					default: wave_nxt = wave_r;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wave_r <= 1'b0;
			ovr_r  <= 1'b0;
		end else begin
			wave_r <= wave_nxt;
			ovr_r  <= ovr_nxt;
		end
	end

	assign wave_out     = wave_r;
	assign pin_override = ovr_r;
endmodule

// ===== verilog/tco_timer.sv
// 16-bit timer with three compare-output channels behind an apb slave
// assumes a single clk_sys domain; pin drivers and direction bits lie outside
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps

// Behaviour
// (RQ1) count and flags only on tick enable
// (RQ2) compare buffered only in double-buffered modes
// (RQ3) bottom-update pwm loads compares at bottom
// (RQ4) bottom overflow flag timed like top
// (RQ5) ctc and fast pwm wrap top to bottom
// (RQ6) dual-slope modes reverse direction at top
// (RQ7) fast pwm sets overflow, capture at top
// (RQ8) control: modes a,b,c then low waveform bits
// (RQ9) nonzero output mode overrides port pin; not a barred toggle or mode 13
// (RQ10) software sets pin direction to output
// (RQ11) non-pwm: off, toggle, clear, set on match
// (RQ12) fast toggle only channel a, modes 14-15
// (RQ13) fast 10: clear on match, set top
// (RQ14) fast 11: set on match, clear top
// (RQ15) fast: match at top ignored, top wins
// (RQ16) dual toggle only channel a, modes 8-11
// (RQ17) dual 10: clear up, set down
// (RQ18) dual 11: set up, clear down
// (RQ19) four-bit waveform mode decode table
// (RQ20) dual: bottom holds low, top holds high
// (RQ21) match on tick count, output next edge
module tco_timer (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_count_pin,
	output logic             chan_a_wave_out,
	output logic             chan_b_wave_out,
	output logic             chan_c_wave_out,
	output logic             chan_a_pin_override,
	output logic             chan_b_pin_override,
	output logic             chan_c_pin_override
);
	import tco_pkg::*;

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [7:0]  timer1_output_mode_control_r;
	logic [7:0]  timer1_output_mode_control_nxt;
	logic [7:0]  ctrl_b_r;
	logic [7:0]  ctrl_b_nxt;
	logic [15:0] count_value_r;
	logic [15:0] count_value_nxt;
	tco_dir_t    dir_r;
	tco_dir_t    dir_nxt;
	logic [15:0] cmp_buf_r [3];
	logic [15:0] cmp_buf_nxt [3];
	logic [15:0] compare_value_r [3];
	logic [15:0] compare_value_nxt [3];
	logic [15:0] capture_value_r;
	logic [15:0] capture_value_nxt;
	logic [4:0]  flags_r;
	logic [4:0]  flags_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	logic [3:0]  waveform_mode;
	tco_wclass_t wclass;
	tco_topsel_t topsel;
	logic [15:0] top_val;
	logic        at_top;
	logic        at_bottom;
	logic        dbl_buf;
	logic        upd;
	logic        ovf_set;
	logic        cap_set;
	logic [2:0]  match;
	logic        timer_tick_enable;
	logic        wr;
	logic        setup;
	logic        hit;
	logic [4:0]  flag_clr;
	logic [4:0]  flag_set;
	tco_chan_t   chan [3];
	logic [2:0]  wave;
	logic [2:0]  ovr;

	assign waveform_mode = {ctrl_b_r[CTRL_B_WGM_LSB +: 2],
		timer1_output_mode_control_r[CTRL_A_WGM_LSB +: 2]};

	// mode 13 is reserved: counter holds and pins stay released
	always_comb begin
		wclass = WC_NORMAL;
		topsel = TS_MAX;
		case (waveform_mode) // RQ19
			4'd0:  begin wclass = WC_NORMAL; topsel = TS_MAX;  end
			4'd1:  begin wclass = WC_PHASE;  topsel = TS_8;    end
			4'd2:  begin wclass = WC_PHASE;  topsel = TS_9;    end
			4'd3:  begin wclass = WC_PHASE;  topsel = TS_10;   end
			4'd4:  begin wclass = WC_CTC;    topsel = TS_CMPA; end
			4'd5:  begin wclass = WC_FAST;   topsel = TS_8;    end
			4'd6:  begin wclass = WC_FAST;   topsel = TS_9;    end
			4'd7:  begin wclass = WC_FAST;   topsel = TS_10;   end
			4'd8:  begin wclass = WC_BOTUPD; topsel = TS_CAP;  end
			4'd9:  begin wclass = WC_BOTUPD; topsel = TS_CMPA; end
			4'd10: begin wclass = WC_PHASE;  topsel = TS_CAP;  end
			4'd11: begin wclass = WC_PHASE;  topsel = TS_CMPA; end
			4'd12: begin wclass = WC_CTC;    topsel = TS_CAP;  end
			4'd13: begin wclass = WC_RSVD;   topsel = TS_MAX;  end
			4'd14: begin wclass = WC_FAST;   topsel = TS_CAP;  end
			4'd15: begin wclass = WC_FAST;   topsel = TS_CMPA; end
			default: begin wclass = WC_NORMAL; topsel = TS_MAX; end
		endcase
		case (topsel)
			TS_8:    top_val = VAL_TOP8;
			TS_9:    top_val = VAL_TOP9;
			TS_10:   top_val = VAL_TOP10;
			TS_CMPA: top_val = compare_value_r[0];
			TS_CAP:  top_val = capture_value_r;
			default: top_val = VAL_MAX;
		endcase
	end

	assign at_top    = (count_value_r == top_val);
	assign at_bottom = (count_value_r == VAL_BOTTOM);
	// immediate-update modes write straight through (RQ2)
	assign dbl_buf   = (wclass == WC_PHASE) || (wclass == WC_FAST) || (wclass == WC_BOTUPD);

	// --------------------------------------------------------------
	// tick source
	// --------------------------------------------------------------
	tco_tick_gen u_tick (
		.clk_sys           (clk_sys),
		.arst_n            (arst_n),
		.clk_sel           (ctrl_b_r[CTRL_B_CS_LSB +: 3]),
		.ext_count_pin     (ext_count_pin),
		.timer_tick_enable (timer_tick_enable)
	);

	// --------------------------------------------------------------
	// counter sequencing
	// --------------------------------------------------------------
	always_comb begin
		count_value_nxt = count_value_r;
		dir_nxt         = dir_r;
		upd             = 1'b0;
		ovf_set         = 1'b0;
		cap_set         = 1'b0;
		if (timer_tick_enable) begin // RQ1
			case (wclass)
				WC_NORMAL: begin
					count_value_nxt = count_value_r + 16'h0001;
					ovf_set         = (count_value_r == VAL_MAX);
				end
				WC_CTC: begin
					// a top below the count runs on to max and wraps there
					count_value_nxt = at_top ? VAL_BOTTOM : count_value_r + 16'h0001; // RQ5
					ovf_set         = (count_value_r == VAL_MAX);
				end
				WC_FAST: begin
					count_value_nxt = at_top ? VAL_BOTTOM : count_value_r + 16'h0001; // RQ5
					ovf_set         = at_top; // RQ7
					cap_set         = at_top && (topsel == TS_CAP); // RQ7
					upd             = at_top;
				end
				WC_PHASE, WC_BOTUPD: begin
					if (dir_r == DIR_UP) begin
						if (at_top && !at_bottom) begin
							dir_nxt         = DIR_DOWN; // RQ6
							count_value_nxt = count_value_r - 16'h0001;
						end else begin
							count_value_nxt = count_value_r + 16'h0001;
						end
					end else begin
						if (at_bottom) begin
							dir_nxt         = DIR_UP;
							count_value_nxt = count_value_r + 16'h0001;
						end else begin
							count_value_nxt = count_value_r - 16'h0001; // RQ6
						end
					end
					ovf_set = at_bottom; // RQ4
					cap_set = at_top && (topsel == TS_CAP);
					upd     = (wclass == WC_BOTUPD) ? at_bottom : at_top; // RQ3
				end
				default: count_value_nxt = count_value_r;
			endcase
		end
		if (wr && paddr == OFS_COUNT) begin
			count_value_nxt = pwdata[15:0];
		end
	end

	// --------------------------------------------------------------
	// compare and capture registers
	// --------------------------------------------------------------
	always_comb begin
		capture_value_nxt = capture_value_r;
		if (wr && paddr == OFS_CAP) begin
			capture_value_nxt = pwdata[15:0];
		end
		for (int i = 0; i < 3; i++) begin
			cmp_buf_nxt[i]       = cmp_buf_r[i];
			compare_value_nxt[i] = compare_value_r[i];
			if (upd) begin
				compare_value_nxt[i] = cmp_buf_r[i]; // RQ2
			end
			if (wr && paddr == OFS_CMP_A + 8'(4 * i)) begin
				cmp_buf_nxt[i] = pwdata[15:0];
				if (!dbl_buf) begin
					compare_value_nxt[i] = pwdata[15:0]; // RQ2
				end
			end
		end
	end

	// --------------------------------------------------------------
	// compare channels
	// --------------------------------------------------------------
	for (genvar g = 0; g < 3; g++) begin : g_chan
		always_comb begin
			chan[g].mode      = timer1_output_mode_control_r[CTRL_A_CHA_LSB - 2 * g +: 2]; // RQ8
			chan[g].match     = timer_tick_enable && (count_value_r == compare_value_r[g]); // RQ21
			chan[g].eq_top    = (compare_value_r[g] == top_val);
			chan[g].eq_bottom = (compare_value_r[g] == VAL_BOTTOM);
			match[g]          = chan[g].match;
		end

		tco_chan_out #(
			.IS_A (g == 0)
		) u_chan (
			.clk_sys      (clk_sys),
			.arst_n       (arst_n),
			.tick         (timer_tick_enable),
			.wclass       (wclass),
			.wgm          (waveform_mode),
			.at_top       (at_top),
			.dir          (dir_r),
			.ch           (chan[g]),
			.wave_out     (wave[g]),
			.pin_override (ovr[g])
		);
	end

	// the pin driver also needs its direction bit set in the port (RQ10)
	assign chan_a_wave_out     = wave[0];
	assign chan_b_wave_out     = wave[1];
	assign chan_c_wave_out     = wave[2];
	assign chan_a_pin_override = ovr[0]; // RQ9
	assign chan_b_pin_override = ovr[1];
	assign chan_c_pin_override = ovr[2];

	// --------------------------------------------------------------
	// flags: hardware set wins over write-one clear
	// --------------------------------------------------------------
	always_comb begin
		flag_set = {match, cap_set, ovf_set};
		flag_clr = (wr && paddr == OFS_FLAGS) ? pwdata[4:0] : 5'h00;
		flags_nxt = (flags_r & ~flag_clr) | flag_set;
	end

	// --------------------------------------------------------------
	// apb slave, zero wait, read data latched in setup
	// --------------------------------------------------------------
	assign setup  = psel && !penable;
	assign wr     = psel && penable && pwrite;
	assign pready = 1'b1;

	always_comb begin
		timer1_output_mode_control_nxt = timer1_output_mode_control_r;
		ctrl_b_nxt                     = ctrl_b_r;
		if (wr && paddr == OFS_CTRL_A) begin
			timer1_output_mode_control_nxt = pwdata[7:0]; // RQ8
		end
		if (wr && paddr == OFS_CTRL_B) begin
			ctrl_b_nxt = pwdata[7:0] & CTRL_B_MSK;
		end
		hit        = 1'b1;
		prdata_nxt = prdata_r;
		case (paddr)
			OFS_CTRL_A: prdata_nxt = {24'h00_0000, timer1_output_mode_control_r};
			OFS_CTRL_B: prdata_nxt = {24'h00_0000, ctrl_b_r};
			OFS_COUNT:  prdata_nxt = {16'h0000, count_value_r};
			OFS_CMP_A:  prdata_nxt = {16'h0000, cmp_buf_r[0]};
			OFS_CMP_B:  prdata_nxt = {16'h0000, cmp_buf_r[1]};
			OFS_CMP_C:  prdata_nxt = {16'h0000, cmp_buf_r[2]};
			OFS_CAP:    prdata_nxt = {16'h0000, capture_value_r};
			OFS_FLAGS:  prdata_nxt = {27'h000_0000, flags_r};
			OFS_PINS:   prdata_nxt = {25'h000_0000, dir_r, ovr, wave};
			default: begin
				hit        = 1'b0;
				prdata_nxt = 32'h0000_0000;
			end
		endcase
		if (!setup) begin
			prdata_nxt = prdata_r;
		end
		pslverr_nxt = setup ? !hit : pslverr_r;
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r & psel & penable;

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timer1_output_mode_control_r <= CTRL_RST;
			ctrl_b_r                     <= CTRL_RST;
			count_value_r                <= CNT_RST;
			dir_r                        <= DIR_UP;
			capture_value_r              <= CNT_RST;
			flags_r                      <= FLAGS_RST;
			prdata_r                     <= 32'h0000_0000;
			pslverr_r                    <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				cmp_buf_r[i]       <= CNT_RST;
				compare_value_r[i] <= CNT_RST;
			end
		end else begin
			timer1_output_mode_control_r <= timer1_output_mode_control_nxt;
			ctrl_b_r                     <= ctrl_b_nxt;
			count_value_r                <= count_value_nxt;
			dir_r                        <= dir_nxt;
			capture_value_r              <= capture_value_nxt;
			flags_r                      <= flags_nxt;
			prdata_r                     <= prdata_nxt;
			pslverr_r                    <= pslverr_nxt;
			for (int i = 0; i < 3; i++) begin
				cmp_buf_r[i]       <= cmp_buf_nxt[i];
				compare_value_r[i] <= compare_value_nxt[i];
			end
		end
	end
endmodule

// ===== tb/tco_pin_model.sv
// pad model: port pads that the compare outputs take over
// assumes the bench drives direction and port data bits
`timescale 1ns/100ps
module tco_pin_model (
	input  wire logic [2:0] wave,
	input  wire logic [2:0] ovr,
	input  wire logic [2:0] dir_out,
	input  wire logic [2:0] port_val,
	output logic      [2:0] pin
);
	// --------------------------------------------------------------
	// pads with pull-up: a pad not driven reads high
	// --------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin[i] = dir_out[i] ? (ovr[i] ? wave[i] : port_val[i]) : 1'b1;
		end
	end
endmodule

// ===== tb/tco_timer_properties.sv
// assertions on the apb, pin-override and wave ports of the timer
// assumes control registers change only through apb writes
`timescale 1ns/100ps
module tco_timer_properties (
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ext_count_pin,
	input wire logic        chan_a_wave_out,
	input wire logic        chan_b_wave_out,
	input wire logic        chan_c_wave_out,
	input wire logic        chan_a_pin_override,
	input wire logic        chan_b_pin_override,
	input wire logic        chan_c_pin_override
);
	import tco_pkg::*;
	logic       acc;
	logic       wr_a;
	logic [3:0] wgm_w;
	logic [2:0] ovr_w;
	logic [2:0] ovr;
	logic [2:0] wave;
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_a_nxt;
	logic [4:0] ctrl_b_r;
	logic [4:0] ctrl_b_nxt;
	assign acc   = psel && penable;
	assign wr_a  = acc && pwrite && paddr == OFS_CTRL_A;
	assign wgm_w = {ctrl_b_r[4:3], pwdata[1:0]};
	assign ovr_w = {|pwdata[7:6], |pwdata[5:4], |pwdata[3:2]};
	assign ovr   = {chan_a_pin_override, chan_b_pin_override, chan_c_pin_override};
	assign wave  = {chan_a_wave_out, chan_b_wave_out, chan_c_wave_out};
	always_comb begin
		ctrl_a_nxt = wr_a ? pwdata[7:0] : ctrl_a_r;
		ctrl_b_nxt = (acc && pwrite && paddr == OFS_CTRL_B) ? pwdata[4:0] : ctrl_b_r;
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_a_r <= CTRL_RST;
			ctrl_b_r <= 5'h00;
		end else begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	a_err_unmapped: assert property (
		acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_PINS))
		else $error("bad slave error");
	a_err_idle: assert property (!acc |-> !pslverr)
		else $error("slave error outside an access phase");
	a_read_ctrl: assert property (
		acc && !pwrite && paddr == OFS_CTRL_A |-> prdata == {24'h00_0000, ctrl_a_r})
		else $error("bad control read");
	a_override_plain: assert property (
		wr_a && wgm_w inside {4'd0, 4'd4, 4'd12} |-> ##2 ovr == $past(ovr_w, 2))
		else $error("bad non-pwm override");
	a_override_fast: assert property (
		wr_a && wgm_w inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15} && pwdata[7] |-> ##2 ovr[2])
		else $error("channel a not on its pin in fast pwm");
	a_fast_toggle_b: assert property (
		wr_a && wgm_w inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15} && pwdata[5:4] == 2'b01
		|-> ##2 !chan_b_pin_override)
		else $error("fast toggle on b");
	a_dual_toggle_a: assert property (
		wr_a && wgm_w inside {[4'd1:4'd3], [4'd8:4'd11]} && pwdata[7:6] == 2'b01
		|-> ##2 chan_a_pin_override == $past(wgm_w[3], 2))
		else $error("bad dual toggle on a");
	a_reserved_off: assert property (wr_a && wgm_w == 4'd13 |-> ##2 ovr == 3'b000)
		else $error("reserved mode left a pin overridden");
	a_stopped_frozen: assert property (
		ctrl_b_r[2:0] == 3'd0 && $past(ctrl_b_r[2:0]) == 3'd0 |=> $stable(wave))
		else $error("wave moved while stopped");
endmodule

bind tco_timer tco_timer_properties i_props (
	.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
	.chan_a_wave_out(chan_a_wave_out), .chan_b_wave_out(chan_b_wave_out),
	.chan_c_wave_out(chan_c_wave_out), .chan_a_pin_override(chan_a_pin_override),
	.chan_b_pin_override(chan_b_pin_override), .chan_c_pin_override(chan_c_pin_override)
);

// ===== tb/tb_top.sv
// self-checking bench for the timer compare-output block
// assumes one clock; apb master, pad model and row table live here
`timescale 1ns/100ps
module tb_top;
	import tco_pkg::*;
	// --------------------------------------------------------------
	// rows: write, read, measure
	// --------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  op;
		logic [7:0]  addr;
		logic [15:0] data;
	} tco_row_t;
	localparam logic [1:0] W = 2'd0;
	localparam logic [1:0] R = 2'd1;
	localparam logic [1:0] M = 2'd3;
	logic        clk_sys;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  wave;
	logic [2:0]  ovr;
	logic [2:0]  pin;
	logic [2:0]  dir_out;
	logic [31:0] rd;
	logic        err;
	int          fails;
	int          check_count;
	int          cycles;
	int          na;
	int          nbc;
	tco_row_t    rows[$];
	tco_timer i_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_count_pin(1'b0),
		.chan_a_wave_out(wave[2]), .chan_b_wave_out(wave[1]), .chan_c_wave_out(wave[0]),
		.chan_a_pin_override(ovr[2]), .chan_b_pin_override(ovr[1]),
		.chan_c_pin_override(ovr[0])
	);
	tco_pin_model i_pads (
		.wave(wave), .ovr(ovr), .dir_out(dir_out), .port_val(3'b000), .pin(pin)
	);
	task automatic test_done();
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		check_count++;
		if (got != exp) begin
			fails++;
			$display("unexpected at %0t: high %0d want %0d", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// window of 80 ticks spans whole periods of every mode used
	task automatic measure();
		na  = 0;
		nbc = 0;
		repeat (16) @(posedge clk_sys);
		repeat (80) begin
			@(posedge clk_sys);
			na  += int'(pin[2] === 1'b1);
			nbc += int'(pin[1] === 1'b1) + int'(pin[0] === 1'b1);
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 10000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		arst_n  = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		dir_out = 3'b111;
		rows = '{'{R,8'h00,16'h0000}, '{R,8'h08,16'h0000}, '{W,8'h00,16'h00FC},
			'{R,8'h00,16'h00FC}, '{R,8'h20,16'h0038}, '{W,8'h04,16'h00FF},
			'{R,8'h04,16'h001F}, '{W,8'h04,16'h0018}, '{W,8'h00,16'h00FD},
			'{R,8'h20,16'h0000}, '{W,8'h18,16'h0004}, '{W,8'h0C,16'h0004},
			'{R,8'h0C,16'h0004}, '{W,8'h10,16'h0002}, '{W,8'h14,16'h0002},
			'{W,8'h04,16'h0019}, '{W,8'h00,16'h0000}, '{M,8'h00,16'h0000},
			'{W,8'h00,16'h0054}, '{M,8'h00,16'h2828}, '{W,8'h00,16'h00A8},
			'{M,8'h00,16'h0000}, '{W,8'h00,16'h00FC}, '{M,8'h00,16'h5050},
			'{W,8'h04,16'h0018}, '{W,8'h1C,16'h001F}, '{W,8'h0C,16'h0002},
			'{W,8'h00,16'h0082}, '{W,8'h04,16'h0019}, '{M,8'h00,16'h3000},
			'{R,8'h1C,16'h001F}, '{W,8'h00,16'h00C2}, '{M,8'h00,16'h2000},
			'{W,8'h0C,16'h0004}, '{W,8'h00,16'h0082}, '{M,8'h00,16'h5000},
			'{W,8'h00,16'h00C2}, '{M,8'h00,16'h0000}, '{W,8'h00,16'h0052},
			'{M,8'h00,16'h2800}, '{W,8'h04,16'h0011}, '{W,8'h0C,16'h0001},
			'{W,8'h00,16'h0082}, '{M,8'h00,16'h1400}, '{W,8'h00,16'h00C2},
			'{M,8'h00,16'h3C00}, '{W,8'h0C,16'h0000}, '{W,8'h00,16'h0082},
			'{M,8'h00,16'h0000}, '{W,8'h0C,16'h0004}, '{M,8'h00,16'h5000},
			'{W,8'h00,16'h0042}, '{M,8'h00,16'h2800}, '{W,8'h0C,16'h0001},
			'{W,8'h00,16'h0080}, '{M,8'h00,16'h1400}};
		repeat (8) @(posedge clk_sys);
		chk_data({26'h000_0000, ovr, wave}, 32'h0000_0000);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].op == M) begin
				measure();
				chk_cnt(na, int'(rows[i].data[15:8]));
				chk_cnt(nbc, 2 * int'(rows[i].data[7:0]));
			end else begin
				apb(rows[i].op == W, rows[i].addr, {16'h0000, rows[i].data});
				if (rows[i].op == R) begin
					chk_data(rd, {16'h0000, rows[i].data});
				end
			end
		end
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk_data({31'h0000_0000, err}, 32'h0000_0001);
		chk_data(rd, 32'h0000_0000);
		dir_out <= 3'b000;
		measure();
		chk_cnt(na + nbc, 240);
		arst_n <= 1'b0;
		@(posedge clk_sys);
		chk_data({26'h000_0000, ovr, wave}, 32'h0000_0000);
		arst_n <= 1'b1;
		apb(1'b0, OFS_CTRL_A, 32'h0000_0000);
		chk_data(rd, 32'h0000_0000);
		test_done();
	end
endmodule
